// [rtl/pfc_consts.vh]
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
`define PFC_MAX_NEST        5'd24
`define PFC_MAX_TIMER       8'h7f
`define PFC_TICK_MS         100
`define PFC_CLK_MHZ         100
`define PFC_TICK_CYC        (`PFC_TICK_MS * 1000 * `PFC_CLK_MHZ)
`define PFC_CLK_WD_CYC      8'd64
`define PFC_NO_DB_ADDR      16'h7fff
`define PFC_VEC_DI_BASE     16'he200
`define PFC_VEC_DO_BASE     16'he280
`define PFC_VEC_KI_BASE     16'he300
`define PFC_VEC_KO_BASE     16'he400
`define PFC_BLINK_CYC       24'd5000000
`define PFC_A_CAUSE         12'h000
`define PFC_A_INSTR         12'h004
`define PFC_A_STEP          12'h008
`define PFC_A_REL           12'h00c
`define PFC_A_CALL          12'h010
`define PFC_A_DBB           12'h014
`define PFC_A_VEC           12'h018
`define PFC_A_CFG           12'h01c
`define PFC_A_STAT          12'h020
`define PFC_A_CTRL          12'h024
`define PFC_CFG_RST         32'h0000_0000
`define PFC_MEM_RAM_LARGE   2'd0
`define PFC_MEM_RAM_MEDIUM  2'd1
`define PFC_MEM_RAM_SMALL   2'd2
`define PFC_MEM_EPROM       2'd3
`define PFC_C_BSO   0
`define PFC_C_TE    1
`define PFC_C_ACK   2
`define PFC_C_ADR   3
`define PFC_C_OPC   4
`define PFC_C_SFG   5
`define PFC_C_SFM   6
`define PFC_C_SFE   7
`define PFC_C_IUE   8
`define PFC_C_ION   9
`define PFC_C_HALT  10
`define PFC_C_STOP  11
`define PFC_C_IOL   12
`define PFC_C_TOV   13
`define PFC_C_CLK   14
`endif

// [rtl/pfc_tick_gen.v]
`timescale 1ns/1ps
`include "pfc_consts.vh"
module pfc_tick_gen #(
  parameter TICK_CYC = `PFC_TICK_CYC
) (
  input  wire core_clk_in,
  input  wire rst_n_in,
  output reg  tick_out
);
  reg [31:0] cnt_r;
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r    <= 32'h0;
      tick_out <= 1'b0;
    end
    else if (cnt_r == TICK_CYC - 1)
    begin
      cnt_r    <= 32'h0;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_r    <= cnt_r + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule // pfc_tick_gen

// [rtl/pfc_clk_watch.v]
`timescale 1ns/1ps
`include "pfc_consts.vh"
// Watches a processor clock pulse sampled as a level; a missing toggle for the window is a loss.
module pfc_clk_watch (
  input  wire core_clk_in,
  input  wire rst_n_in,
  input  wire proc_pulse_in,
  output reg  lost_out
);
  reg       prev_r;
  reg [7:0] cnt_r;
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev_r   <= 1'b0;
      cnt_r    <= 8'h0;
      lost_out <= 1'b0;
    end
    else
    begin
      prev_r <= proc_pulse_in;
      if (proc_pulse_in != prev_r)
        cnt_r <= 8'h0;
      else if (cnt_r != `PFC_CLK_WD_CYC)
        cnt_r <= cnt_r + 8'h1;
      lost_out <= (cnt_r == `PFC_CLK_WD_CYC);
    end
  end
endmodule // pfc_clk_watch

// [rtl/pfc_fault_capture.v]
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pfc_consts.vh"
// Overview of operation
// - Flag block stack overflow when a call would push nesting beyond 24.
// - Raise time error on a new 100 ms tick while tick handling busy.
// - Raise time error also when the processor clock pulse fails.
// - Flag ack timeout when an addressed backplane module gives no acknowledge.
// - Flag addressing error on image access to absent or undeclared I/O.
// - Flag illegal opcode for timer or counter above 127 or masked.
// - Flag illegal opcode when a call targets an unloaded block.
// - Special function group error follows missing or execution special-function flag.
// - Digital input image ack error records E200H to E27FH in vector address.
// - Digital output image ack error records E280H to E2FFH in vector address.
// - Flag input transfer ack error records E300H to E3FFH.
// - Flag output transfer ack error records E400H to E4FFH.
// - Report 7FFFH as data block base when no data block selected.
// - Snapshot depth numbers entries in chronological interrupt order.
// - With main and fallback blocks both loaded, run only the main block.
// - Snapshot stores first word of the next or just-executed instruction.
// - Snapshot stores block-relative step address besides absolute step address.
// - Snapshot stores absolute address of last call in calling block.
// - Set I/O-not-operable cause on expansion unit power failure.
// - Set halt cause when halt line is driven by coordinator or CPU.
// - One stop cause for selector stop, stop command or programmer stop.
// - In multiprocessor mode with image updating on (CFG bit 4), raise I/O list error if list block missing.
// - Report user memory as large, medium or small RAM, or EPROM.
// - Any error stops the CPU, flashes stop lamp, asserts output disable.
module pfc_fault_capture #(
  parameter TICK_CYC = `PFC_TICK_CYC
) (
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        call_in,
  input  wire        block_end_in,
  input  wire        call_target_loaded_in,
  input  wire        tick_done_in,
  input  wire        proc_pulse_in,
  input  wire        bus_access_in,
  input  wire        bus_ack_timeout_in,
  input  wire        image_access_in,
  input  wire        image_addr_valid_in,
  input  wire        timer_access_in,
  input  wire [7:0]  timer_num_in,
  input  wire        timer_masked_in,
  input  wire        special_func_missing_in,
  input  wire        special_func_exec_error_in,
  input  wire        update_ack_err_in,
  input  wire [1:0]  update_kind_in,
  input  wire [7:0]  update_entry_in,
  input  wire        exp_power_fail_in,
  input  wire        halt_line_in,
  input  wire        mode_stop_in,
  input  wire        stop_cmd_in,
  input  wire        pg_stop_in,
  input  wire        multiproc_in,
  input  wire        io_list_present_in,
  input  wire        restart_in,
  input  wire [15:0] instruction_word_in,
  input  wire [15:0] step_address_in,
  input  wire [15:0] block_start_in,
  input  wire        db_selected_in,
  input  wire [15:0] db_addr_in,
  output reg         stopped_out,
  output reg         stop_led_out,
  output reg         output_disable_out,
  output reg         run_main_block_out,
  output reg         run_fallback_block_out,
  output wire        tick_request_out
);
  reg  [14:0] cause_r;
  reg  [14:0] cause_nxt;
  reg  [4:0]  depth_r;
  reg         tick_busy_r;
  reg  [15:0] instr_r;
  reg  [15:0] step_r;
  reg  [15:0] rel_r;
  reg  [15:0] call_addr_r;
  reg  [15:0] last_call_r;
  reg  [15:0] dbb_r;
  reg  [15:0] vec_r;
  reg  [3:0]  snap_depth_r;
  reg  [31:0] cfg_r;
  reg  [23:0] blink_r;
  reg  [11:0] aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         aw_have_r;
  reg         w_have_r;
  wire        clk_lost;
  wire        tick;
  wire        fault;
  wire        main_loaded     = cfg_r[0];
  wire        fallback_loaded = cfg_r[1];
  wire        image_updating  = cfg_r[4];
  // Start-up code writes the fitted memory module type to CFG bits 3:2; it is shown one-hot.
  wire [3:0]  mem_kind        = 4'h1 << cfg_r[3:2];

  function [15:0] vec_of;
    input [1:0] kind;
    input [7:0] entry;
    begin
      case (kind)
        2'd0:    vec_of = `PFC_VEC_DI_BASE + {9'h0, entry[6:0]};
        2'd1:    vec_of = `PFC_VEC_DO_BASE + {9'h0, entry[6:0]};
        2'd2:    vec_of = `PFC_VEC_KI_BASE + {8'h0, entry};
        default: vec_of = `PFC_VEC_KO_BASE + {8'h0, entry};
      endcase
    end
  endfunction

  pfc_tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .tick_out    (tick)
  );

  pfc_clk_watch u_watch (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .proc_pulse_in (proc_pulse_in),
    .lost_out      (clk_lost)
  );

  assign tick_request_out = tick & ~stopped_out;

  always @*
  begin
    cause_nxt = 15'h0;
    cause_nxt[`PFC_C_BSO] = call_in & call_target_loaded_in
                            & (depth_r == `PFC_MAX_NEST);
    cause_nxt[`PFC_C_TOV] = tick & tick_busy_r;
    cause_nxt[`PFC_C_CLK] = clk_lost;
    cause_nxt[`PFC_C_TE]  = cause_nxt[`PFC_C_TOV] | clk_lost;
    cause_nxt[`PFC_C_ACK] = bus_access_in & bus_ack_timeout_in;
    cause_nxt[`PFC_C_ADR] = image_access_in & ~image_addr_valid_in;
    cause_nxt[`PFC_C_OPC] = (timer_access_in & (timer_masked_in
                            | (timer_num_in > `PFC_MAX_TIMER)))
                            | (call_in & ~call_target_loaded_in);
    cause_nxt[`PFC_C_SFM] = special_func_missing_in;
    cause_nxt[`PFC_C_SFE] = special_func_exec_error_in;
    cause_nxt[`PFC_C_SFG] = special_func_missing_in | special_func_exec_error_in;
    cause_nxt[`PFC_C_IUE] = update_ack_err_in;
    cause_nxt[`PFC_C_ION] = exp_power_fail_in;
    cause_nxt[`PFC_C_HALT] = halt_line_in;
    cause_nxt[`PFC_C_STOP] = mode_stop_in | stop_cmd_in | pg_stop_in;
    cause_nxt[`PFC_C_IOL] = multiproc_in & ~io_list_present_in & image_updating;
  end

  assign fault = |cause_nxt;

  // Causes latch only while running or in the restart cycle, so the first picture stays intact for the programmer.
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cause_r      <= 15'h0;
      stopped_out  <= 1'b0;
      depth_r      <= 5'h0;
      tick_busy_r  <= 1'b0;
      instr_r      <= 16'h0;
      step_r       <= 16'h0;
      rel_r        <= 16'h0;
      call_addr_r  <= 16'h0;
      last_call_r  <= 16'h0;
      dbb_r        <= `PFC_NO_DB_ADDR;
      vec_r        <= 16'h0;
      snap_depth_r <= 4'h0;
    end
    else
    begin
      if (restart_in)
      begin
        cause_r      <= 15'h0;
        stopped_out  <= 1'b0;
        depth_r      <= 5'h0;
        tick_busy_r  <= 1'b0;
        snap_depth_r <= 4'h0;
      end
      else if (!stopped_out)
      begin
        if (call_in && call_target_loaded_in && depth_r != `PFC_MAX_NEST)
        begin
          depth_r     <= depth_r + 5'h1;
          last_call_r <= step_address_in;
        end
        else if (block_end_in && depth_r != 5'h0)
          depth_r <= depth_r - 5'h1;
        if (tick)
          tick_busy_r <= 1'b1;
        else if (tick_done_in)
          tick_busy_r <= 1'b0;
      end
      // A fault in the restart cycle wins over the clear, so no error slips through unseen.
      if (fault && (restart_in || !stopped_out))
      begin
        stopped_out  <= 1'b1;
        cause_r      <= cause_nxt;
        snap_depth_r <= restart_in ? 4'h1 : snap_depth_r + 4'h1;
        instr_r      <= instruction_word_in;
        step_r       <= step_address_in;
        rel_r        <= step_address_in - block_start_in;
        call_addr_r  <= last_call_r;
        dbb_r        <= db_selected_in ? db_addr_in : `PFC_NO_DB_ADDR;
        vec_r        <= update_ack_err_in ? vec_of(update_kind_in, update_entry_in)
                                          : step_address_in;
      end
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      blink_r                <= 24'h0;
      stop_led_out           <= 1'b0;
      output_disable_out     <= 1'b1;
      run_main_block_out     <= 1'b0;
      run_fallback_block_out <= 1'b0;
    end
    else
    begin
      output_disable_out <= stopped_out;
      if (!stopped_out)
      begin
        blink_r      <= 24'h0;
        stop_led_out <= 1'b0;
      end
      else if (blink_r == `PFC_BLINK_CYC - 24'h1)
      begin
        blink_r      <= 24'h0;
        stop_led_out <= ~stop_led_out;
      end
      else
        blink_r <= blink_r + 24'h1;
      run_main_block_out     <= ~stopped_out & main_loaded;
      run_fallback_block_out <= ~stopped_out & fallback_loaded & ~main_loaded;
    end
  end

  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign s_axi_bresp   = 2'b00;

  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      aw_addr_r    <= 12'h0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      cfg_r        <= `PFC_CFG_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_have_r && w_have_r)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r[11:2] == `PFC_A_CFG >> 2)
        begin
          if (w_strb_r[0])
            cfg_r[7:0] <= w_data_r[7:0];
          if (w_strb_r[1])
            cfg_r[15:8] <= w_data_r[15:8];
          if (w_strb_r[2])
            cfg_r[23:16] <= w_data_r[23:16];
          if (w_strb_r[3])
            cfg_r[31:24] <= w_data_r[31:24];
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Unmapped reads answer zero with OKAY rather than an error, so scans of the map are harmless.
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr[11:2])
        `PFC_A_CAUSE >> 2: s_axi_rdata <= {17'h0, cause_r};
        `PFC_A_INSTR >> 2: s_axi_rdata <= {16'h0, instr_r};
        `PFC_A_STEP  >> 2: s_axi_rdata <= {16'h0, step_r};
        `PFC_A_REL   >> 2: s_axi_rdata <= {16'h0, rel_r};
        `PFC_A_CALL  >> 2: s_axi_rdata <= {16'h0, call_addr_r};
        `PFC_A_DBB   >> 2: s_axi_rdata <= {16'h0, dbb_r};
        `PFC_A_VEC   >> 2: s_axi_rdata <= {16'h0, vec_r};
        `PFC_A_CFG   >> 2: s_axi_rdata <= cfg_r;
        `PFC_A_STAT  >> 2: s_axi_rdata <= {16'h0, snap_depth_r, 1'b0, depth_r,
                                           mem_kind, tick_busy_r, stopped_out};
        default:           s_axi_rdata <= 32'h0;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // pfc_fault_capture

// [testbench/pfc_fault_capture_sva.sv]
`timescale 1ns/1ps
module pfc_fault_sva (
  input wire       core_clk_in,
  input wire       rst_n_in,
  input wire       bus_access_in,
  input wire       bus_ack_timeout_in,
  input wire       image_access_in,
  input wire       image_addr_valid_in,
  input wire       timer_access_in,
  input wire [7:0] timer_num_in,
  input wire       special_func_missing_in,
  input wire       exp_power_fail_in,
  input wire       halt_line_in,
  input wire       stop_cmd_in,
  input wire       restart_in,
  input wire       stopped_out,
  input wire       output_disable_out,
  input wire       run_main_block_out,
  input wire       run_fallback_block_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Events while already stopped are ignored, so only a running core is judged.
  wire run_ok = !stopped_out && !restart_in;
  property p_ack; run_ok && bus_access_in && bus_ack_timeout_in |=> stopped_out; endproperty
  a_ack: assert property (p_ack) else $error("no stop on ack timeout");
  property p_adr; run_ok && image_access_in && !image_addr_valid_in |=> stopped_out; endproperty
  a_adr: assert property (p_adr) else $error("no stop on bad image access");
  property p_tmr; run_ok && timer_access_in && timer_num_in > 8'h7f |=> stopped_out; endproperty
  a_tmr: assert property (p_tmr) else $error("no stop on timer number");
  property p_sfm; run_ok && special_func_missing_in |=> stopped_out; endproperty
  a_sfm: assert property (p_sfm) else $error("no stop on special function");
  property p_pwr; run_ok && exp_power_fail_in |=> stopped_out; endproperty
  a_pwr: assert property (p_pwr) else $error("no stop on power fail");
  property p_hlt; run_ok && halt_line_in |=> stopped_out; endproperty
  a_hlt: assert property (p_hlt) else $error("no stop on halt line");
  property p_stp; run_ok && stop_cmd_in |=> stopped_out; endproperty
  a_stp: assert property (p_stp) else $error("no stop on stop command");
  property p_dis; stopped_out && $past(stopped_out) |-> output_disable_out; endproperty
  a_dis: assert property (p_dis) else $error("outputs not disabled");
  property p_hold; stopped_out && !restart_in |=> stopped_out; endproperty
  a_hold: assert property (p_hold) else $error("stop dropped without restart");
  property p_sel; !(run_main_block_out && run_fallback_block_out); endproperty
  a_sel: assert property (p_sel) else $error("both cyclic blocks selected");
  c_stop: cover property ($rose(stopped_out));
  c_main: cover property (run_main_block_out);
  c_rst: cover property (restart_in && stopped_out);
endmodule // pfc_fault_sva
bind pfc_fault_capture pfc_fault_sva chk_u (.core_clk_in, .rst_n_in, .bus_access_in,
  .bus_ack_timeout_in, .image_access_in, .image_addr_valid_in, .timer_access_in,
  .timer_num_in, .special_func_missing_in, .exp_power_fail_in, .halt_line_in, .stop_cmd_in,
  .restart_in, .stopped_out, .output_disable_out, .run_main_block_out,
  .run_fallback_block_out);

// [testbench/pfc_bp_model.sv]
`timescale 1ns/1ps
module pfc_bp_model #(
  parameter DLY = 3
) (
  input  wire core_clk_in,
  input  wire rst_n_in,
  input  wire req_in,
  input  wire present_in,
  output wire access_out,
  output wire timeout_out
);
  localparam [3:0] DLY_W = DLY;
  reg [3:0] cnt_r;
  // An absent module never answers, so the access ends in a timeout report.
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_r <= 4'h0;
    else if (req_in)
      cnt_r <= DLY_W;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  assign access_out  = (cnt_r == 4'h1);
  assign timeout_out = (cnt_r == 4'h1) && !present_in;
endmodule // pfc_bp_model

// [testbench/tb.sv]
`timescale 1ns/1ps
`include "pfc_consts.vh"
module tb;
  reg         core_clk_in = 1'b0;
  reg         rst_n_in    = 1'b0;
  reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg  [31:0] wdata  = 32'h0, rd_v = 32'h0;
  reg  [3:0]  ws     = 4'hf;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid, acc, tmo;
  wire        stopped, led, od, rmain, rfb, treq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  reg  [15:0] ev = 16'h0, iw = 16'h34c8, sa = 16'h004f;
  reg  [1:0]  uk = 2'd0;
  reg  [7:0]  ue = 8'h00;
  reg         ld = 1'b1, pr = 1'b1, ad = 1'b1, ph = 1'b0, pp = 1'b0, tdone = 1'b0, rs = 1'b0;
  reg         lp = 1'b1;
  integer     err_total = 0, compares = 0;

  always #5 core_clk_in = ~core_clk_in;
  // The processor pulse toggles and each tick is finished at once, unless held back.
  always @(posedge core_clk_in)
  begin
    pp <= ph ? pp : ~pp;
    tdone <= treq && ad;
  end

  pfc_bp_model #(.DLY(3)) io_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .req_in(ev[12]), .present_in(pr), .access_out(acc), .timeout_out(tmo));

  pfc_fault_capture #(.TICK_CYC(50)) dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .call_in(ev[9]), .block_end_in(ev[14]), .call_target_loaded_in(ld), .tick_done_in(tdone),
    .proc_pulse_in(pp), .bus_access_in(acc), .bus_ack_timeout_in(tmo),
    .image_access_in(ev[0]), .image_addr_valid_in(ev[15]), .timer_access_in(ev[1] | ev[11]),
    .timer_num_in({~ev[15], 7'h7f}), .timer_masked_in(ev[11]),
    .special_func_missing_in(ev[2]), .special_func_exec_error_in(ev[3]),
    .update_ack_err_in(ev[10]), .update_kind_in(uk), .update_entry_in(ue),
    .exp_power_fail_in(ev[4]), .halt_line_in(ev[5]), .mode_stop_in(ev[6]),
    .stop_cmd_in(ev[7]), .pg_stop_in(ev[8]), .multiproc_in(ev[13]), .io_list_present_in(lp),
    .restart_in(rs), .instruction_word_in(iw), .step_address_in(sa),
    .block_start_in(16'h004d), .db_selected_in(ev[0]), .db_addr_in(16'h002c),
    .stopped_out(stopped), .stop_led_out(led), .output_disable_out(od),
    .run_main_block_out(rmain), .run_fallback_block_out(rfb), .tick_request_out(treq));

  task final_report;
  begin
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  task bail;
  begin
    err_total = err_total + 1;
    $display("MISMATCH t=%0t wait limit reached", $time);
    final_report;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    integer n;
  begin
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    while (!(bready && bvalid))
    begin
      if (n == 50) bail;
      n = n + 1;
      @(posedge core_clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(bresp, 2'b00);
    @(posedge core_clk_in);
  end
  endtask

  task rdr(input [11:0] a);
    integer n;
  begin
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    while (!(rready && rvalid))
    begin
      if (n == 50) bail;
      n = n + 1;
      @(posedge core_clk_in);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    rd_v = rdata;
    chk(rresp, 2'b00);
    @(posedge core_clk_in);
  end
  endtask

  task rd(input [11:0] a, input [31:0] e);
  begin
    rdr(a);
    chk(rd_v, e);
  end
  endtask

  // Snapshot inputs change only after the stop, so the latched values must outlive them.
  task fire(input [15:0] e, input [15:0] c, input [15:0] v);
    integer n;
  begin
    ev <= e;
    @(posedge core_clk_in);
    ev <= 16'h0000;
    n = 0;
    while (stopped !== 1'b1)
    begin
      if (n == 300) bail;
      n = n + 1;
      @(posedge core_clk_in);
    end
    iw <= ~iw;
    // The pulse resumes while stopped, so a clock loss has cleared before the restart.
    ph <= 1'b0;
    sa <= 16'h0100;
    ev <= 16'h0020;
    @(posedge core_clk_in);
    ev <= 16'h0000;
    chk({od, led}, 2'b10);
    rd(`PFC_A_CAUSE, {16'h0, c});
    rd(`PFC_A_INSTR, 32'h34c8);
    rd(`PFC_A_STEP, 32'h004f);
    rd(`PFC_A_REL, 32'h0002);
    rd(`PFC_A_VEC, {16'h0, v});
    rd(`PFC_A_DBB, e[0] ? 32'h002c : 32'h7fff);
    rd(`PFC_A_CALL, 32'h004f);
    rdr(`PFC_A_STAT);
    chk(rd_v[15:12], 4'h1);
    chk(rd_v[5:2], 4'h4);
    chk(rd_v[0], 1'b1);
    rs <= 1'b1;
    ad <= 1'b1;
    @(posedge core_clk_in);
    rs <= 1'b0;
    sa <= 16'h004f;
    iw <= 16'h34c8;
    repeat (2) @(posedge core_clk_in);
    chk(stopped, 1'b0);
    $display("fault case %h done", c);
  end
  endtask

  task t_regs;
  begin
    rd(`PFC_A_CFG, `PFC_CFG_RST);
    rd(`PFC_A_DBB, 32'h7fff);
    rd(12'h040, 32'h0);
    wr(`PFC_A_CAUSE, 32'hffff_ffff);
    rd(`PFC_A_CAUSE, 32'h0);
    wr(`PFC_A_CFG, 32'h3);
    @(posedge core_clk_in);
    chk({rmain, rfb}, 2'b10);
    wr(`PFC_A_CFG, 32'h2);
    @(posedge core_clk_in);
    chk({rmain, rfb}, 2'b01);
    wr(`PFC_A_CFG, 32'h18);
    ws <= 4'he;
    wr(`PFC_A_CFG, 32'h0000_00ff);
    ws <= 4'hf;
    rd(`PFC_A_CFG, 32'h18);
    $display("register test done");
  end
  endtask

  task t_quiet;
    integer n;
  begin
    ev <= 16'hb203;
    @(posedge core_clk_in);
    ev <= 16'h4000;
    @(posedge core_clk_in);
    ev <= 16'h0000;
    repeat (8) @(posedge core_clk_in);
    chk(stopped, 1'b0);
    // Align to a tick so the read lands in the one cycle in which tick handling is busy.
    n = 0;
    @(negedge core_clk_in);
    while (treq !== 1'b1)
    begin
      if (n == 60) bail;
      n = n + 1;
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    rd(`PFC_A_STAT, 32'h12);
    $display("quiet test done");
  end
  endtask

  task t_ovf;
  begin
    repeat (24)
    begin
      ev <= 16'h0200;
      @(posedge core_clk_in);
      ev <= 16'h0000;
      @(posedge core_clk_in);
    end
    ev <= 16'h4000;
    @(posedge core_clk_in);
    ev <= 16'h0200;
    @(posedge core_clk_in);
    ev <= 16'h0000;
    repeat (2) @(posedge core_clk_in);
    chk(stopped, 1'b0);
    fire(16'h0200, 16'h0001, 16'h004f);
  end
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk_in);
    chk(od, 1'b1);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    t_regs;
    t_quiet;
    fire(16'h0001, 16'h0008, 16'h004f);
    fire(16'h0002, 16'h0010, 16'h004f);
    fire(16'h8800, 16'h0010, 16'h004f);
    ld <= 1'b0;
    fire(16'h0200, 16'h0010, 16'h004f);
    ld <= 1'b1;
    fire(16'h0004, 16'h0060, 16'h004f);
    fire(16'h0008, 16'h00a0, 16'h004f);
    fire(16'h0010, 16'h0200, 16'h004f);
    fire(16'h0020, 16'h0400, 16'h004f);
    fire(16'h0040, 16'h0800, 16'h004f);
    fire(16'h0080, 16'h0800, 16'h004f);
    fire(16'h0100, 16'h0800, 16'h004f);
    pr <= 1'b0;
    fire(16'h1000, 16'h0004, 16'h004f);
    pr <= 1'b1;
    lp <= 1'b0;
    fire(16'h2000, 16'h1000, 16'h004f);
    lp <= 1'b1;
    ue <= 8'h85;
    fire(16'h0400, 16'h0100, 16'he205);
    uk <= 2'd1;
    fire(16'h0400, 16'h0100, 16'he285);
    uk <= 2'd2;
    ue <= 8'hff;
    fire(16'h0400, 16'h0100, 16'he3ff);
    uk <= 2'd3;
    ue <= 8'h10;
    fire(16'h0400, 16'h0100, 16'he410);
    ad <= 1'b0;
    fire(16'h0000, 16'h2002, 16'h004f);
    ph <= 1'b1;
    fire(16'h0000, 16'h4002, 16'h004f);
    t_ovf;
    final_report;
  end
endmodule // tb
